// [rtl/gtm_timer.sv]
// General-purpose 16-bit timer control with an AHB-Lite register slave
`timescale 1ns/10ps
`include "gtm_consts.svh"
// Contract
// - Select bit picks pin or comparator input
// - Deadband code gives extra delay cycles in PWM modes
// - Gap between output off and complement on
// - Flag shows last interrupt was capture
// - Run bit stops or runs timer
// - Disabled output equals polarity bit
// - One-shot output pulses one cycle after reload
// - Other non-PWM modes toggle output on reload
// - Counter mode counts polarity-selected input edges
// - Single PWM: level on match, back on reload
// - Capture mode captures on polarity-selected edges
// - Gated mode counts while input active
// - Capture/compare starts on first edge, then captures
// - Dual PWM complement opposite, delayed rises
// - Triggered one-shot starts on polarity-selected edge
// - Restart and comparator counter capture on edges
// - Prescaler divides by two to the exponent
// - Prescaler cleared while timer disabled
// - Mode code is four bits, twelve modes
// - Snapshot held until next conversion start
// - Control zero bit 7 is mode top bit
// - Config code 10 suppresses reload interrupts
module gtm_timer #(
  parameter int ADDR_W = 32 // Bus address width
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic timer_in_pin,
  input wire logic comp_out,
  input wire logic adc_conv_start,
  output logic timer_out,
  output logic timer_out_n,
  output logic timer_irq
);
  import gtm_pkg::*;

  // Refuse address widths that cannot hold the register window
  if (ADDR_W < 15) begin : gtm_addr_check
    $error("ADDR_W must be at least 15");
  end

  // Mask of prescaler bits that must be all ones for a tick
  function automatic logic [6:0] div_mask(input logic [2:0] p);
    div_mask = 7'((8'h01 << p) - 8'h01);
  endfunction : div_mask

  // Deadband code to extra cycles; unlisted codes give none
  function automatic logic [7:0] db_cycles(input logic [2:0] c);
    case (c)
      3'b001: db_cycles = `GTM_DB_2;
      3'b010: db_cycles = `GTM_DB_4;
      3'b110: db_cycles = `GTM_DB_8;
      3'b101: db_cycles = `GTM_DB_32;
      3'b111: db_cycles = `GTM_DB_128;
      default: db_cycles = `GTM_DB_0;
    endcase
  endfunction : db_cycles

  // Registers seen by software
  logic [7:1] ctl0_reg; // Mode top bit, irq config, select, deadband
  logic cap_flag_reg; // Last interrupt came from a capture
  logic [7:0] ctl1_reg; // Run, polarity, prescale, mode low bits
  logic [15:0] cnt_reg; // Running count
  logic [15:0] rld_reg; // Reload value
  logic [15:0] pwm_reg; // PWM match value, also capture result
  logic [15:0] snap_reg; // Count held for the converter
  logic [15:0] cnt_next;
  logic [15:0] rld_next;
  logic [15:0] pwm_next;
  // Bus slave state
  logic wr_pend_reg; // Write data phase pending
  logic [11:0] wr_idx_reg; // Index of pending write
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic hresp_reg;
  // Input path
  logic [2:0] pin_sync_reg; // Pin synchroniser
  logic [2:0] cmp_sync_reg; // Comparator synchroniser
  logic pin_lvl_reg; // Filtered pin level
  logic cmp_lvl_reg; // Filtered comparator level
  logic tin_q_reg; // Selected input, one cycle back
  // Timer core
  gtm_state_t st_reg;
  gtm_state_t st_next;
  logic [6:0] pre_reg; // Prescaler
  logic out_raw_reg; // Output level before deadband
  logic [7:0] dbc_reg [2]; // Deadband counters, output and complement
  logic [1:0] dout_reg; // Output and complement pins
  logic irq_reg;

  // Field views
  gtm_mode_t mode;
  logic run;
  logic pol;
  logic insel;
  logic [2:0] div_exp;
  logic [2:0] db_code;
  logic [1:0] irq_cfg;
  assign mode = gtm_mode_t'({ctl0_reg[`GTM_C0_MODE_HI],
    ctl1_reg[`GTM_C1_MODE_HI:`GTM_C1_MODE_LO]});
  assign run = ctl1_reg[`GTM_C1_RUN];
  assign pol = ctl1_reg[`GTM_C1_POL];
  assign insel = ctl0_reg[`GTM_C0_INSEL];
  assign div_exp = ctl1_reg[`GTM_C1_DIV_HI:`GTM_C1_DIV_LO];
  assign db_code = ctl0_reg[`GTM_C0_DB_HI:`GTM_C0_DB_LO];
  assign irq_cfg = ctl0_reg[`GTM_C0_IRQ_HI:`GTM_C0_IRQ_LO];

  // Mode classes
  logic pwm_mode;
  logic dual;
  logic cap_mode;
  logic edge_cnt;
  assign pwm_mode = (mode == GTM_M_PWM1) || (mode == GTM_M_PWM2);
  assign dual = (mode == GTM_M_PWM2);
  assign cap_mode = (mode == GTM_M_CAPT) || (mode == GTM_M_CAPCMP) ||
                    (mode == GTM_M_CAPRST) || (mode == GTM_M_CMPCNT);
  assign edge_cnt = (mode == GTM_M_CNTR) || (mode == GTM_M_CMPCNT);

  // Address phase decode
  logic ap_acc;
  logic ap_hit;
  logic [11:0] rd_idx;
  logic [7:0] rd_byte;
  assign ap_acc = hsel && hready && htrans[1];
  assign ap_hit = ap_acc && (hsize == 3'b010) &&
                  (haddr[ADDR_W-1:14] == '0);
  assign rd_idx = haddr[13:2];
  assign rd_byte =
    (rd_idx == `GTM_IDX_CNT_H) ? cnt_reg[15:8] :
    (rd_idx == `GTM_IDX_CNT_L) ? cnt_reg[7:0] :
    (rd_idx == `GTM_IDX_RLD_H) ? rld_reg[15:8] :
    (rd_idx == `GTM_IDX_RLD_L) ? rld_reg[7:0] :
    (rd_idx == `GTM_IDX_PWM_H) ? pwm_reg[15:8] :
    (rd_idx == `GTM_IDX_PWM_L) ? pwm_reg[7:0] :
    (rd_idx == `GTM_IDX_CTL0) ? {ctl0_reg, cap_flag_reg} :
    (rd_idx == `GTM_IDX_CTL1) ? ctl1_reg :
    (rd_idx == `GTM_IDX_SNAP_H) ? snap_reg[15:8] :
    (rd_idx == `GTM_IDX_SNAP_L) ? snap_reg[7:0] : 8'h00;

  // Data phase write strobes, low byte lane carries the value
  logic [7:0] wbyte;
  logic wr_cnt_h, wr_cnt_l, wr_rld_h, wr_rld_l;
  logic wr_pwm_h, wr_pwm_l, wr_ctl0, wr_ctl1;
  assign wbyte = hwdata[7:0];
  assign wr_cnt_h = wr_pend_reg && (wr_idx_reg == `GTM_IDX_CNT_H);
  assign wr_cnt_l = wr_pend_reg && (wr_idx_reg == `GTM_IDX_CNT_L);
  assign wr_rld_h = wr_pend_reg && (wr_idx_reg == `GTM_IDX_RLD_H);
  assign wr_rld_l = wr_pend_reg && (wr_idx_reg == `GTM_IDX_RLD_L);
  assign wr_pwm_h = wr_pend_reg && (wr_idx_reg == `GTM_IDX_PWM_H);
  assign wr_pwm_l = wr_pend_reg && (wr_idx_reg == `GTM_IDX_PWM_L);
  assign wr_ctl0 = wr_pend_reg && (wr_idx_reg == `GTM_IDX_CTL0);
  assign wr_ctl1 = wr_pend_reg && (wr_idx_reg == `GTM_IDX_CTL1);

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 12'h000;
      hrdata_reg <= 32'h0000_0000;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else begin
      wr_pend_reg <= ap_hit && hwrite;
      wr_idx_reg <= rd_idx;
      // Reads answer in the data phase; unmapped reads give zero
      if (ap_acc && !hwrite) begin
        hrdata_reg <= ap_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
    end
  end
  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;

  // Input synchronisers; a level counts once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_sync_reg <= 3'b000;
      cmp_sync_reg <= 3'b000;
      pin_lvl_reg <= 1'b0;
      cmp_lvl_reg <= 1'b0;
      tin_q_reg <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[1:0], timer_in_pin};
      cmp_sync_reg <= {cmp_sync_reg[1:0], comp_out};
      if (pin_sync_reg[1] == pin_sync_reg[2]) begin
        pin_lvl_reg <= pin_sync_reg[2];
      end
      if (cmp_sync_reg[1] == cmp_sync_reg[2]) begin
        cmp_lvl_reg <= cmp_sync_reg[2];
      end
      tin_q_reg <= insel ? cmp_lvl_reg : pin_lvl_reg;
    end
  end

  // Selected input and its edges
  logic tin;
  logic rise;
  logic fall;
  logic act_edge;
  logic gate_on;
  logic gate_off;
  assign tin = insel ? cmp_lvl_reg : pin_lvl_reg;
  assign rise = tin && !tin_q_reg;
  assign fall = !tin && tin_q_reg;
  // Polarity 0 selects rising edges, 1 falling
  assign act_edge = pol ? fall : rise;
  assign gate_on = pol ? !tin : tin;
  assign gate_off = pol ? rise : fall;

  logic reload; // Count reached reload value on a tick
  // Run sequence: some modes wait for a start edge first
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      GTM_ST_IDLE: begin
        if (run) begin
          st_next = ((mode == GTM_M_CAPCMP) || (mode == GTM_M_TRIG)) ?
                    GTM_ST_WAIT : GTM_ST_RUN;
        end
      end
      GTM_ST_WAIT: begin
        if (act_edge) begin
          st_next = GTM_ST_RUN;
        end
      end
      GTM_ST_RUN: begin
        if (reload && ((mode == GTM_M_ONE) || (mode == GTM_M_TRIG))) begin
          st_next = GTM_ST_DONE;
        end
      end
      GTM_ST_DONE: begin
        if ((mode == GTM_M_TRIG) && act_edge) begin
          st_next = GTM_ST_RUN;
        end
      end
      default: st_next = GTM_ST_IDLE;
    endcase
    if (!run) begin
      st_next = GTM_ST_IDLE;
    end
  end

  // Counting, prescaling and reload
  logic idle;
  logic cnt_en;
  logic base;
  logic tick;
  logic match;
  logic cap_ev;
  logic restart;
  assign idle = (st_reg == GTM_ST_IDLE);
  assign cnt_en = (st_reg == GTM_ST_RUN) &&
                  ((mode != GTM_M_GATE) || gate_on);
  assign base = edge_cnt ? act_edge : 1'b1;
  assign tick = cnt_en && base &&
                ((pre_reg & div_mask(div_exp)) == div_mask(div_exp));
  assign reload = tick && (cnt_reg == rld_reg);
  assign match = tick && (cnt_reg == pwm_reg);
  assign cap_ev = (st_reg == GTM_ST_RUN) && act_edge &&
                  cap_mode;
  assign restart = cap_ev && (mode == GTM_M_CAPRST);
  // Software writes win over hardware updates
  assign cnt_next = wr_cnt_h ? {wbyte, cnt_reg[7:0]} :
                    wr_cnt_l ? {cnt_reg[15:8], wbyte} :
                    (reload || restart) ? `GTM_RST_CNT :
                    tick ? cnt_reg + 16'h0001 : cnt_reg;
  assign rld_next = wr_rld_h ? {wbyte, rld_reg[7:0]} :
                    wr_rld_l ? {rld_reg[15:8], wbyte} : rld_reg;
  assign pwm_next = wr_pwm_h ? {wbyte, pwm_reg[7:0]} :
                    wr_pwm_l ? {pwm_reg[15:8], wbyte} :
                    cap_ev ? cnt_reg : pwm_reg;

  // Interrupt sources after configuration
  logic irq_rl;
  logic irq_cap;
  logic irq_gate;
  logic irq_any;
  assign irq_rl = reload && (irq_cfg != `GTM_IRQ_NO_RELOAD);
  // Comparator counter captures raise no interrupt of their own
  assign irq_cap = cap_ev && (mode != GTM_M_CMPCNT) &&
                   (irq_cfg != `GTM_IRQ_RELOAD_ONLY);
  assign irq_gate = (mode == GTM_M_GATE) && (st_reg == GTM_ST_RUN) &&
                    gate_off && (irq_cfg != `GTM_IRQ_RELOAD_ONLY);
  assign irq_any = irq_rl || irq_cap || irq_gate;

  // Control and data registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl0_reg <= 7'(`GTM_RST_CTL >> 1);
      ctl1_reg <= `GTM_RST_CTL;
      cap_flag_reg <= 1'b0;
      cnt_reg <= `GTM_RST_CNT;
      rld_reg <= `GTM_RST_RLD;
      pwm_reg <= `GTM_RST_PWM;
      snap_reg <= `GTM_RST_SNAP;
    end else begin
      if (wr_ctl0) begin
        ctl0_reg <= wbyte[7:1];
      end
      if (wr_ctl1) begin
        ctl1_reg <= wbyte;
      end
      if (irq_any) begin
        cap_flag_reg <= irq_cap;
      end
      cnt_reg <= cnt_next;
      rld_reg <= rld_next;
      pwm_reg <= pwm_next;
      if (adc_conv_start) begin
        snap_reg <= cnt_reg;
      end
    end
  end

  // Sequence state, prescaler, raw output and interrupt pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= GTM_ST_IDLE;
      pre_reg <= 7'h00;
      out_raw_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      irq_reg <= irq_any;
      if (idle) begin
        pre_reg <= 7'h00;
      end else if (cnt_en && base) begin
        pre_reg <= pre_reg + 7'h01;
      end
      if (idle) begin
        out_raw_reg <= pol;
      end else if (mode == GTM_M_ONE) begin
        out_raw_reg <= reload ? !pol : pol;
      end else if (pwm_mode) begin
        if (reload) begin
          out_raw_reg <= pol;
        end else if (match) begin
          out_raw_reg <= !pol;
        end
      end else if (reload) begin
        out_raw_reg <= !out_raw_reg;
      end
    end
  end

  // Deadband: in PWM modes rising edges wait the extra cycles, falls are immediate
  logic [1:0] tgt;
  logic [7:0] db_load;
  assign tgt[0] = idle ? pol : out_raw_reg;
  assign tgt[1] = dual ? !tgt[0] : 1'b0;
  assign db_load = db_cycles(db_code);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dout_reg <= 2'b00;
      dbc_reg[0] <= 8'h00;
      dbc_reg[1] <= 8'h00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!pwm_mode || idle || !tgt[i]) begin
          dout_reg[i] <= tgt[i];
          dbc_reg[i] <= db_load;
        end else if (!dout_reg[i]) begin
          if (dbc_reg[i] == 8'h00) begin
            dout_reg[i] <= 1'b1;
          end else begin
            dbc_reg[i] <= dbc_reg[i] - 8'h01;
          end
        end
      end
    end
  end
  assign timer_out = dout_reg[0];
  assign timer_out_n = dout_reg[1];
  assign timer_irq = irq_reg;

  // Checks of the block's own behaviour
  default clocking gtm_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  src_select_a:
  assert property ((insel && $stable(insel)) |->
    (tin_q_reg == $past(cmp_lvl_reg)))
    else $error("selected input does not follow comparator");

  idle_out_a:
  assert property (idle |=> (timer_out == $past(pol)))
    else $error("disabled output differs from polarity");

  one_shot_a:
  assert property ((mode == GTM_M_ONE && reload) |=>
    (out_raw_reg == !$past(pol)) ##1 (out_raw_reg == $past(pol)))
    else $error("one-shot pulse is not one cycle");

  toggle_a:
  assert property ((mode == GTM_M_CONT && !idle && reload) |=>
    (out_raw_reg != $past(out_raw_reg)))
    else $error("output did not toggle on reload");

  div_clear_a:
  assert property (idle |=> (pre_reg == 7'h00))
    else $error("prescaler not cleared while disabled");

  div_tick_a:
  assert property ((div_exp == 3'b011 && pre_reg[2:0] != 3'b111) |-> !tick)
    else $error("tick outside divide-by-eight boundary");

  reload_a:
  assert property ((reload && !wr_cnt_h && !wr_cnt_l) |=>
    (cnt_reg == `GTM_RST_CNT))
    else $error("count not restarted on reload");

  snap_hold_a:
  assert property (adc_conv_start |=> (snap_reg == $past(cnt_reg)) ##1
    (adc_conv_start || $stable(snap_reg)))
    else $error("snapshot not taken or not held");

  dual_gap_a:
  assert property ((dual && $past(dual)) |-> !(timer_out && timer_out_n))
    else $error("output and complement active together");

  deadband_a:
  assert property ((pwm_mode && !idle && !$past(idle) &&
    db_code == 3'b001 &&
    $stable(db_code) && $rose(timer_out)) |-> $past(tgt[0], 3))
    else $error("deadband shorter than two cycles");

  capflag_a:
  assert property (irq_any |=> (cap_flag_reg == $past(irq_cap)))
    else $error("capture flag does not match last interrupt");

  irq_off_a:
  assert property ((irq_cfg == `GTM_IRQ_NO_RELOAD &&
    (!cap_mode || mode == GTM_M_CMPCNT) &&
    mode != GTM_M_GATE) |=> !timer_irq)
    else $error("interrupt raised while suppressed");

  one_shot_c: cover property (mode == GTM_M_ONE && reload);
  capture_c: cover property (cap_ev && mode == GTM_M_CAPCMP);
  dual_c: cover property (dual && db_code != 3'b000 && $rose(timer_out_n));
  snap_c: cover property (adc_conv_start && cnt_reg != 16'h0000);
endmodule : gtm_timer

// [rtl/gtm_consts.svh]
// Register indexes, field positions, reset values and counts of the timer
`ifndef GTM_CONSTS_SVH
`define GTM_CONSTS_SVH
// Register indexes; byte address is four times the index
`define GTM_IDX_CNT_H 12'hF00
`define GTM_IDX_CNT_L 12'hF01
`define GTM_IDX_RLD_H 12'hF02
`define GTM_IDX_RLD_L 12'hF03
`define GTM_IDX_PWM_H 12'hF04
`define GTM_IDX_PWM_L 12'hF05
`define GTM_IDX_CTL0 12'hF06
`define GTM_IDX_CTL1 12'hF07
`define GTM_IDX_SNAP_H 12'hF08
`define GTM_IDX_SNAP_L 12'hF09
// Control zero fields
`define GTM_C0_MODE_HI 7
`define GTM_C0_IRQ_HI 6
`define GTM_C0_IRQ_LO 5
`define GTM_C0_INSEL 4
`define GTM_C0_DB_HI 3
`define GTM_C0_DB_LO 1
// Control one fields
`define GTM_C1_RUN 7
`define GTM_C1_POL 6
`define GTM_C1_DIV_HI 5
`define GTM_C1_DIV_LO 3
`define GTM_C1_MODE_HI 2
`define GTM_C1_MODE_LO 0
// Reset values
`define GTM_RST_CTL 8'h00
`define GTM_RST_CNT 16'h0001
`define GTM_RST_RLD 16'hFFFF
`define GTM_RST_PWM 16'h0000
`define GTM_RST_SNAP 16'h0000
// Interrupt configuration codes
`define GTM_IRQ_NO_RELOAD 2'b10
`define GTM_IRQ_RELOAD_ONLY 2'b11
// Deadband cycle counts
`define GTM_DB_0 8'h00
`define GTM_DB_2 8'h02
`define GTM_DB_4 8'h04
`define GTM_DB_8 8'h08
`define GTM_DB_32 8'h20
`define GTM_DB_128 8'h80
`endif

// [rtl/gtm_pkg.sv]
// Types shared by the general timer control block
package gtm_pkg;
  // Operating modes, control zero bit 7 on top of control one bits 2:0
  typedef enum logic [3:0] {
    GTM_M_ONE = 4'h0,
    GTM_M_CONT = 4'h1,
    GTM_M_CNTR = 4'h2,
    GTM_M_PWM1 = 4'h3,
    GTM_M_CAPT = 4'h4,
    GTM_M_CMPR = 4'h5,
    GTM_M_GATE = 4'h6,
    GTM_M_CAPCMP = 4'h7,
    GTM_M_PWM2 = 4'h8,
    GTM_M_CAPRST = 4'h9,
    GTM_M_CMPCNT = 4'hA,
    GTM_M_TRIG = 4'hB
  } gtm_mode_t;
  // Run sequence, Gray coded
  typedef enum logic [1:0] {
    GTM_ST_IDLE = 2'b00,
    GTM_ST_WAIT = 2'b01,
    GTM_ST_RUN = 2'b11,
    GTM_ST_DONE = 2'b10
  } gtm_state_t;
endpackage : gtm_pkg

// [verification/gtm_input_src.sv]
// Model of the external timer input pin and the comparator output
`timescale 1ns/10ps
module gtm_input_src (
  input wire logic hclk,
  output logic pin,
  output logic comp
);
  // Both lines start low
  initial begin
    pin = 1'b0;
    comp = 1'b0;
  end
  // Moves one line after an edge, then holds it well past the filter
  task automatic drive(input logic sel, input logic lvl);
    @(posedge hclk);
    if (sel) begin
      comp <= lvl;
    end else begin
      pin <= lvl;
    end
    repeat (8) @(posedge hclk);
  endtask : drive
endmodule : gtm_input_src

// [verification/testbench.sv]
// Self-checking testbench for the general timer control block
`timescale 1ns/10ps
`include "gtm_consts.svh"
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic adc_conv_start = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic timer_out;
  logic timer_out_n;
  logic timer_irq;
  logic pin;
  logic comp;
  wire hready = hreadyout;
  int n_fail = 0;
  int checks_done = 0;
  int irq_cnt = 0;
  // Clock of 10 ns
  always #5 hclk = ~hclk;
  // Counts interrupt pulses
  always @(posedge hclk) begin
    if (timer_irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end
  gtm_timer #(.ADDR_W(32)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timer_in_pin(pin),
    .comp_out(comp), .adc_conv_start(adc_conv_start),
    .timer_out(timer_out), .timer_out_n(timer_out_n),
    .timer_irq(timer_irq));
  gtm_input_src src (.hclk(hclk), .pin(pin), .comp(comp));
  // Prints the counts and the verdict, then ends the run
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  // Compares one value and reports a mismatch
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // Waits for hready at a rising edge, bounded
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      give_verdict();
    end
  endtask : wait_ready
  // One single AHB-Lite word transfer
  task automatic xfer(input logic wr, input logic [11:0] idx,
      input logic [7:0] wd, output logic [7:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {18'h00000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'b010;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    wait_ready();
    rd = hrdata[7:0];
    cmp({31'h0, hresp}, 32'h0);
  endtask : xfer
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [7:0] r;
    xfer(1'b1, idx, d, r);
  endtask : wr
  task automatic rd_chk(input logic [11:0] idx, input logic [7:0] e);
    logic [7:0] r;
    xfer(1'b0, idx, 8'h00, r);
    cmp({24'h0, r}, {24'h0, e});
  endtask : rd_chk
  // Loads count and reload with the timer stopped
  task automatic load(input logic [15:0] cnt, input logic [15:0] rl);
    wr(`GTM_IDX_CNT_H, cnt[15:8]);
    wr(`GTM_IDX_CNT_L, cnt[7:0]);
    wr(`GTM_IDX_RLD_H, rl[15:8]);
    wr(`GTM_IDX_RLD_L, rl[7:0]);
  endtask : load
  // Counts cycles up to the next interrupt pulse
  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (timer_irq !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      n_fail++;
      give_verdict();
    end
  endtask : wait_irq
  // Reset values, unmapped place and read-only bits
  task automatic t_regs;
    logic [7:0] e [11] = '{8'h00, 8'h01, 8'hFF, 8'hFF, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 11; i++) begin
      rd_chk(12'hF00 + 12'(i), e[i]);
    end
    wr(`GTM_IDX_SNAP_H, 8'hAA);
    rd_chk(`GTM_IDX_SNAP_H, 8'h00);
    wr(`GTM_IDX_CTL0, 8'h01);
    rd_chk(`GTM_IDX_CTL0, 8'h00);
    wr(`GTM_IDX_CTL1, 8'h3A);
    rd_chk(`GTM_IDX_CTL1, 8'h3A);
    wr(`GTM_IDX_CTL1, 8'h00);
  endtask : t_regs
  // Stopped output follows the polarity bit
  task automatic t_idle;
    wr(`GTM_IDX_CTL1, 8'h40);
    repeat (3) @(posedge hclk);
    cmp({31'h0, timer_out}, 32'h1);
    wr(`GTM_IDX_CTL1, 8'h00);
    repeat (3) @(posedge hclk);
    cmp({31'h0, timer_out}, 32'h0);
  endtask : t_idle
  // Continuous mode period for three prescale settings
  task automatic t_prescale;
    int n;
    logic o1;
    for (int p = 0; p < 3; p++) begin
      wr(`GTM_IDX_CTL1, 8'h01);
      wr(`GTM_IDX_CTL0, 8'h00);
      load(16'h0001, 16'h0003);
      wr(`GTM_IDX_CTL1, 8'h81 | 8'(p << 3));
      wait_irq(n);
      o1 = timer_out;
      wait_irq(n);
      cmp(32'(n), 32'(3 << p));
      cmp({31'h0, timer_out}, {31'h0, ~o1});
    end
    wr(`GTM_IDX_CTL1, 8'h01);
  endtask : t_prescale
  // Config code 10 silences reload interrupts, output still toggles
  task automatic t_irq_off;
    int c0;
    int tg;
    logic po;
    wr(`GTM_IDX_CTL0, 8'h40);
    load(16'h0001, 16'h0003);
    wr(`GTM_IDX_CTL1, 8'h81);
    c0 = irq_cnt;
    tg = 0;
    po = timer_out;
    repeat (40) begin
      @(posedge hclk);
      if (timer_out !== po) tg++;
      po = timer_out;
    end
    cmp(32'(irq_cnt - c0), 32'h0);
    cmp({31'h0, tg >= 10}, 32'h1);
    wr(`GTM_IDX_CTL1, 8'h01);
    wr(`GTM_IDX_CTL0, 8'h00);
  endtask : t_irq_off
  // Snapshot taken on conversion start and held; stopped count holds
  task automatic t_snapshot;
    load(16'h1234, 16'hFFFF);
    repeat (20) @(posedge hclk);
    rd_chk(`GTM_IDX_CNT_L, 8'h34);
    @(posedge hclk);
    adc_conv_start <= 1'b1;
    @(posedge hclk);
    adc_conv_start <= 1'b0;
    rd_chk(`GTM_IDX_SNAP_H, 8'h12);
    rd_chk(`GTM_IDX_SNAP_L, 8'h34);
    load(16'h5678, 16'hFFFF);
    rd_chk(`GTM_IDX_SNAP_L, 8'h34);
  endtask : t_snapshot
  // Counter mode: edge direction and input source
  task automatic t_counter;
    logic [7:0] c0t [3] = '{8'h00, 8'h10, 8'h00};
    logic [7:0] c1t [3] = '{8'h82, 8'h82, 8'hC2};
    logic selt [3] = '{1'b0, 1'b1, 1'b0};
    logic idt [3] = '{1'b0, 1'b0, 1'b1};
    int c0;
    for (int k = 0; k < 3; k++) begin
      wr(`GTM_IDX_CTL1, c1t[k] & 8'h7F);
      wr(`GTM_IDX_CTL0, c0t[k]);
      load(16'h0001, 16'h0002);
      src.drive(selt[k], idt[k]);
      wr(`GTM_IDX_CTL1, c1t[k]);
      c0 = irq_cnt;
      src.drive(selt[k], ~idt[k]);
      src.drive(selt[k], idt[k]);
      cmp(32'(irq_cnt - c0), 32'h0);
      src.drive(selt[k], ~idt[k]);
      cmp(32'(irq_cnt - c0), 32'h1);
    end
    wr(`GTM_IDX_CTL1, 8'h00);
    wr(`GTM_IDX_CTL0, 8'h00);
  endtask : t_counter
  // Capture mode: one rising edge stores the count and sets the flag
  task automatic t_capture;
    int c0;
    load(16'h0005, 16'hFFFF);
    wr(`GTM_IDX_CTL1, 8'hBC);
    c0 = irq_cnt;
    src.drive(1'b0, 1'b1);
    src.drive(1'b0, 1'b0);
    cmp(32'(irq_cnt - c0), 32'h1);
    rd_chk(`GTM_IDX_PWM_L, 8'h05);
    rd_chk(`GTM_IDX_CTL0, 8'h01);
    wr(`GTM_IDX_CTL1, 8'h00);
  endtask : t_capture
  // One-shot output pulses for exactly one cycle
  task automatic t_one_shot;
    int hi;
    load(16'h0001, 16'h0003);
    wr(`GTM_IDX_CTL1, 8'h80);
    hi = 0;
    repeat (40) begin
      @(posedge hclk);
      if (timer_out === 1'b1) hi++;
    end
    cmp(32'(hi), 32'h1);
    wr(`GTM_IDX_CTL1, 8'h00);
  endtask : t_one_shot
  // Dual output PWM: never both high, rises wait the deadband
  task automatic t_deadband;
    logic [2:0] ct [4] = '{3'b001, 3'b010, 3'b110, 3'b101};
    int dt [4] = '{2, 4, 8, 32};
    int fo, fn, rises, bad;
    logic po, pn;
    for (int k = 0; k < 4; k++) begin
      wr(`GTM_IDX_CTL1, 8'h00);
      wr(`GTM_IDX_CTL0, 8'h80 | {4'h0, ct[k], 1'b0});
      load(16'h0001, 16'h0080);
      wr(`GTM_IDX_PWM_H, 8'h00);
      wr(`GTM_IDX_PWM_L, 8'h40);
      wr(`GTM_IDX_CTL1, 8'h80);
      po = timer_out;
      pn = timer_out_n;
      fo = 0;
      fn = 0;
      rises = 0;
      bad = 0;
      for (int c = 1; c <= 600; c++) begin
        @(posedge hclk);
        if (timer_out === 1'b1 && timer_out_n === 1'b1) bad++;
        if (po === 1'b1 && timer_out === 1'b0) fo = c;
        if (pn === 1'b1 && timer_out_n === 1'b0) fn = c;
        if (po === 1'b0 && timer_out === 1'b1) begin
          rises++;
          if (c - fn < dt[k]) bad++;
        end
        if (pn === 1'b0 && timer_out_n === 1'b1) begin
          rises++;
          if (c - fo < dt[k]) bad++;
        end
        po = timer_out;
        pn = timer_out_n;
      end
      cmp(32'(bad), 32'h0);
      cmp({31'h0, rises >= 4}, 32'h1);
    end
    wr(`GTM_IDX_CTL1, 8'h00);
  endtask : t_deadband
  // Main sequence
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_idle();
    t_prescale();
    t_irq_off();
    t_snapshot();
    t_counter();
    t_capture();
    t_one_shot();
    t_deadband();
    give_verdict();
  end
endmodule : testbench
